/* rtl/motion_cmd_core.sv */
// Remote command core: error flags, schedule readback, window channels, hand box, maintenance
//////////////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - At constant speed a detected change is applied well under 320 us.
// - While ramping, a detected change waits for the ramp end, then applies.
// - All four positions detected together: B and D apply 80 us after A and C.
// - Ramp period per kHz follows the rate table, scaled by rate group.
// - Point readback gives condition code, sequence number, then data words.
// - Action readback gives action code, sequence number, then data words.
// - Sequence number field spans 0 to 7F within the stored list.
// - Error flag query returns bits: command, chip busy, bad absolute move.
// - Error status query reports only the lowest set error bit.
// - Clear-all command zeroes the whole error flag.
// - Indexed clear resets only the selected error bit.
// - Assignment maps a channel digit onto each window position in order.
// - A dash digit leaves that position's channel unchanged.
// - Assignment only in remote mode; ignored whole if an affected channel is busy.
// - Window query returns four channel digits in position order.
// - Holding the hand-box button over 3 s in remote lights all lamps, stop mode.
// - In stop mode a button press stops motors moving under remote command.
// - Holding 3 s again in stop mode restores normal speed select.
// - Active program memory reported; selection takes effect at restart.
// - Restart command restarts the program as a power cycle would.
// - Status query returns status port 1 of the four chips, position order.
//////////////////////////////////////////////////////////////////////////////////////////////////
module motion_cmd_core
  import motion_cmd_pkg::*;
#(
  parameter int                  STAGGER_CYCLES = STAGGER_CYC,
  parameter int                  HOLD_CYCLES    = HOLD_CYC,
  parameter logic [63:0]         FW_VERSION     = 64'h0000_0000_0000_0001, // Arbitrary value
  parameter logic [63:0]         HW_VERSION     = 64'h0000_0000_0000_0002  // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  // Decoded command in, reply out
  input  wire logic              cmd_valid,
  input  wire cmd_t              cmd,
  input  wire logic              remote_mode,
  output reply_t                 reply,
  output logic                   reply_valid,
  // Schedule table write port
  input  wire logic              tbl_wr_valid,
  input  wire tbl_wr_t           tbl_wr,
  // Motion side
  input  wire logic [15:0]       chan_busy,
  input  wire logic              busy_error,
  input  wire logic              bad_abs_error,
  input  wire logic [3:0]        change_detect,
  input  wire logic [3:0]        ramping,
  input  wire logic [63:0]       chip_status,
  output logic [3:0]             change_apply,
  output logic [15:0]            window_chan,
  output logic [7:0]             error_flags,
  // Hand box
  input  wire logic              hb_button,
  output logic [2:0]             hb_lamps,
  output logic                   remote_stop,
  // Maintenance
  output logic                   active_rom,
  output logic                   restart_req
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Rate table, microseconds per kHz, only the listed rate numbers
  function automatic logic [31:0] rate_base_us(input logic [6:0] rate);
    case (rate)
      7'd0:    rate_base_us = 32'd1000000;
      7'd7:    rate_base_us = 32'd510000;
      7'd17:   rate_base_us = 32'd200000;
      7'd24:   rate_base_us = 32'd100000;
      7'd31:   rate_base_us = 32'd51000;
      7'd41:   rate_base_us = 32'd20000;
      7'd55:   rate_base_us = 32'd5100;
      7'd60:   rate_base_us = 32'd3300;
      7'd67:   rate_base_us = 32'd1600;
      7'd74:   rate_base_us = 32'd820;
      7'd76:   rate_base_us = 32'd680;
      7'd82:   rate_base_us = 32'd390;
      7'd84:   rate_base_us = 32'd330;
      7'd89:   rate_base_us = 32'd200;
      7'd91:   rate_base_us = 32'd160;
      7'd98:   rate_base_us = 32'd82;
      7'd100:  rate_base_us = 32'd68;
      7'd106:  rate_base_us = 32'd39;
      7'd113:  rate_base_us = 32'd20;
      7'd115:  rate_base_us = 32'd16;
      default: rate_base_us = 32'd0;
    endcase
  endfunction

  // Group scaling, result in nanoseconds so the low groups keep their fractions
  function automatic logic [31:0] ramp_period_ns(input logic [6:0] rate, input logic [2:0] grp);
    logic [31:0] base;
    base = rate_base_us(rate);
    case (grp)
      GRP_L1:  ramp_period_ns = 32'(base * 32'd50);
      GRP_L2:  ramp_period_ns = 32'(base * 32'd250);
      GRP_M1:  ramp_period_ns = 32'(base * 32'd500);
      GRP_M2:  ramp_period_ns = 32'(base * 32'd1000);
      GRP_H1:  ramp_period_ns = 32'(base * 32'd2500);
      GRP_H2:  ramp_period_ns = 32'(base * 32'd10000);
      default: ramp_period_ns = 32'd0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Schedule tables, one slot per channel and sequence number
  logic [7:0]  point_code  [16*NUM_ENTRIES];
  logic [31:0] point_data  [16*NUM_ENTRIES];
  logic [7:0]  action_code [16*NUM_ENTRIES];
  logic [31:0] action_data [16*NUM_ENTRIES];

  wire  [10:0] wr_addr = {tbl_wr.chan, tbl_wr.seq};
  wire  [10:0] rd_addr = {cmd.chan, cmd.seq};

  always_ff @(posedge ref_clk) begin
    if (clk_en && tbl_wr_valid && !tbl_wr.is_action) begin
      point_code[wr_addr] <= tbl_wr.code;
      point_data[wr_addr] <= tbl_wr.data;
    end

    if (clk_en && tbl_wr_valid && tbl_wr.is_action) begin
      action_code[wr_addr] <= tbl_wr.code;
      action_data[wr_addr] <= tbl_wr.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic [7:0]  error_flags_reg;
  logic [15:0] window_chan_reg;
  logic        stop_mode_reg;
  logic        rom_sel_reg;
  logic        active_rom_reg;

  wire op_t   op          = op_t'(cmd.op);
  wire        do_cmd      = clk_en && cmd_valid;
  wire        known_op    = (cmd.op >= 5'h01) && (cmd.op <= 5'h0F);
  wire        remote_only = (op == OP_ASSIGN) || (op == OP_ROM_SEL) || (op == OP_RESTART);
  wire        cmd_refused = do_cmd && (!known_op || (remote_only && !remote_mode));

  // Both the old and the new channel of every replaced position must be idle
  logic [15:0] affected;
  always_comb begin
    affected = 16'h0000;
    for (int p = 0; p < NUM_POS; p++) begin
      if (!cmd.keep_mask[p]) begin
        affected[cmd.win_chan[4*p +: 4]]        = 1'b1;
        affected[window_chan_reg[4*p +: 4]]     = 1'b1;
      end
    end
  end

  wire assign_ok = do_cmd && (op == OP_ASSIGN) && remote_mode
                   && ((affected & chan_busy) == 16'h0000);

  logic [15:0] window_chan_next;
  always_comb begin
    window_chan_next = window_chan_reg;
    for (int p = 0; p < NUM_POS; p++) begin
      if (assign_ok && !cmd.keep_mask[p]) begin
        window_chan_next[4*p +: 4] = cmd.win_chan[4*p +: 4];
      end
    end
  end

  wire do_restart = do_cmd && (op == OP_RESTART) && remote_mode;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Error flags: hardware set wins over a clear in the same cycle
  wire [7:0] err_set   = {5'b00000, bad_abs_error, busy_error, cmd_refused};
  wire       clr_all   = do_cmd && (op == OP_CLR_ALL);
  wire       clr_one   = do_cmd && (op == OP_CLR_ONE) && (cmd.err_idx != 2'd3);
  wire [7:0] err_clr   = clr_all ? 8'hFF : (clr_one ? (8'h01 << cmd.err_idx) : 8'h00);
  wire [7:0] error_flags_next = ((error_flags_reg & ~err_clr) | err_set)
                                & {8{!do_restart}};

  // Lowest set bit only, all ones when nothing is set
  wire [7:0] err_lowest = error_flags_reg[ERR_CMD_BIT]  ? 8'h00 :
                          error_flags_reg[ERR_BUSY_BIT] ? 8'h01 :
                          error_flags_reg[ERR_ABS_BIT]  ? 8'h02 : 8'hFF;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      error_flags_reg <= ERR_RESET;
      window_chan_reg <= WIN_RESET;
    end else if (clk_en) begin
      error_flags_reg <= error_flags_next;
      window_chan_reg <= do_restart ? WIN_RESET : window_chan_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Reply building
  logic [7:0]  reply_code_next;
  logic [7:0]  reply_seq_next;
  logic [63:0] reply_data_next;
  always_comb begin
    reply_code_next = 8'h00;
    reply_seq_next  = {1'b0, cmd.seq};
    reply_data_next = 64'h0;
    case (op)
      OP_ERR_FLAG_Q:   reply_code_next = error_flags_reg;
      OP_ERR_STATUS_Q: reply_code_next = err_lowest;
      OP_POINT_RB: begin
        reply_code_next = point_code[rd_addr];
        reply_data_next = {32'h0, point_data[rd_addr]};
      end
      OP_ACTION_RB: begin
        reply_code_next = action_code[rd_addr];
        reply_data_next = {32'h0, action_data[rd_addr]};
      end
      OP_WIN_Q:        reply_data_next = {48'h0, window_chan_reg};
      OP_CHIP_STAT_Q:  reply_data_next = chip_status;
      OP_ROM_Q:        reply_code_next = {7'h00, active_rom_reg};
      OP_FW_VER_Q:     reply_data_next = FW_VERSION;
      OP_HW_VER_Q:     reply_data_next = HW_VERSION;
      OP_RATE_Q:       reply_data_next = {32'h0, ramp_period_ns(cmd.rate, cmd.group)};
      default:         reply_code_next = 8'h00;
    endcase
  end

  wire is_query = (op == OP_ERR_FLAG_Q) || (op == OP_ERR_STATUS_Q) || (op == OP_POINT_RB)
                  || (op == OP_ACTION_RB) || (op == OP_WIN_Q) || (op == OP_CHIP_STAT_Q)
                  || (op == OP_ROM_Q) || (op == OP_FW_VER_Q) || (op == OP_HW_VER_Q)
                  || (op == OP_RATE_Q);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_valid <= 1'b0;
      reply       <= '0;
    end else if (clk_en) begin
      reply_valid <= do_cmd && is_query;
      if (do_cmd && is_query) begin
        reply <= '{code: reply_code_next, seq: reply_seq_next, data: reply_data_next};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Program memory selection; the new choice only becomes active on restart
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_sel_reg    <= 1'b0;
      active_rom_reg <= 1'b0;
      restart_req    <= 1'b0;
    end else if (clk_en) begin
      restart_req <= do_restart;
      if (do_cmd && (op == OP_ROM_SEL) && remote_mode) begin
        rom_sel_reg <= cmd.rom_sel;
      end
      if (do_restart) begin
        active_rom_reg <= rom_sel_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Scheduled change timing per window position
  logic [3:0]  pending_reg;
  logic [31:0] stagger_cnt_reg [NUM_POS];

  // Simultaneous detection on all four: B and D are served one slot later
  wire all_four = (change_detect == 4'hF);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending_reg  <= 4'h0;
      change_apply <= 4'h0;
      for (int p = 0; p < NUM_POS; p++) begin
        stagger_cnt_reg[p] <= 32'd0;
      end
    end else if (clk_en) begin
      for (int p = 0; p < NUM_POS; p++) begin
        if (change_detect[p]) begin
          pending_reg[p]     <= 1'b1;
          stagger_cnt_reg[p] <= (all_four && p[0]) ? 32'(STAGGER_CYCLES) : 32'd0;
          change_apply[p]    <= 1'b0;
        end else if (stagger_cnt_reg[p] != 32'd0) begin
          stagger_cnt_reg[p] <= stagger_cnt_reg[p] - 32'd1;
          change_apply[p]    <= 1'b0;
        end else if (pending_reg[p] && !ramping[p]) begin
          // Constant speed: one cycle, far under the bound
          pending_reg[p]     <= 1'b0;
          change_apply[p]    <= 1'b1;
        end else begin
          // Still ramping: held until the ramp ends
          change_apply[p]    <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Hand-box button: long hold toggles stop mode once per press
  logic [31:0] hold_cnt_reg;
  logic        hold_done_reg;
  logic        button_d_reg;

  wire press_edge = hb_button && !button_d_reg;
  wire hold_hit   = hb_button && !hold_done_reg && (hold_cnt_reg >= 32'(HOLD_CYCLES));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_reg  <= 32'd0;
      hold_done_reg <= 1'b0;
      button_d_reg  <= 1'b0;
      stop_mode_reg <= 1'b0;
      remote_stop   <= 1'b0;
      hb_lamps      <= 3'b000;
    end else if (clk_en) begin
      button_d_reg <= hb_button;

      if (!hb_button || !remote_mode) begin
        hold_cnt_reg  <= 32'd0;
        hold_done_reg <= 1'b0;
      end else if (!hold_done_reg) begin
        hold_cnt_reg  <= hold_cnt_reg + 32'd1;
      end
      if (hold_hit && remote_mode) begin
        hold_done_reg <= 1'b1;
        stop_mode_reg <= !stop_mode_reg;
      end else if (!remote_mode || do_restart) begin
        stop_mode_reg <= 1'b0;
      end

      remote_stop <= stop_mode_reg && remote_mode && press_edge;
      hb_lamps    <= (stop_mode_reg && remote_mode) ? 3'b111 : 3'b000;
    end
  end

  assign window_chan = window_chan_reg;
  assign error_flags = error_flags_reg;
  assign active_rom  = active_rom_reg;

endmodule

/* rtl/motion_cmd_pkg.sv */
// Package: command codes, reply layout, timing and reset constants
package motion_cmd_pkg;
  localparam int          CLK_MHZ        = 200;
  localparam int          STAGGER_US     = 80;
  localparam int          STAGGER_CYC    = STAGGER_US * CLK_MHZ;
  localparam int          HOLD_S         = 3;
  localparam int          HOLD_CYC       = HOLD_S * CLK_MHZ * 1000000;
  localparam int          NUM_POS        = 4;
  localparam int          NUM_ENTRIES    = 128;
  localparam logic [7:0]  ERR_RESET      = 8'h00;
  localparam int          ERR_CMD_BIT    = 0;
  localparam int          ERR_BUSY_BIT   = 1;
  localparam int          ERR_ABS_BIT    = 2;
  localparam logic [15:0] WIN_RESET      = 16'h3210;
  localparam logic [7:0]  PT_END         = 8'h00;
  localparam logic [7:0]  PT_POSITION    = 8'h01;
  localparam logic [7:0]  PT_ELAPSED     = 8'h02;
  localparam logic [7:0]  PT_ACCEL_SPEED = 8'h80;
  localparam logic [7:0]  PT_DECEL_SPEED = 8'h81;
  localparam logic [7:0]  ACT_NEW_SPEED  = 8'h00;
  localparam logic [7:0]  ACT_NEW_RATE   = 8'h01;
  localparam logic [7:0]  ACT_SLOW_STOP  = 8'h02;
  localparam logic [7:0]  ACT_FAST_STOP  = 8'h03;
  localparam logic [7:0]  ACT_SKIP       = 8'h0F;
  localparam logic [7:0]  SEQ_MAX        = 8'h7F;

  typedef enum logic [4:0] {
    OP_ERR_FLAG_Q   = 5'h01, OP_ERR_STATUS_Q = 5'h02, OP_CLR_ALL     = 5'h03,
    OP_CLR_ONE      = 5'h04, OP_POINT_RB     = 5'h05, OP_ACTION_RB   = 5'h06,
    OP_ASSIGN       = 5'h07, OP_WIN_Q        = 5'h08, OP_CHIP_STAT_Q = 5'h09,
    OP_ROM_Q        = 5'h0A, OP_ROM_SEL      = 5'h0B, OP_RESTART     = 5'h0C,
    OP_FW_VER_Q     = 5'h0D, OP_HW_VER_Q     = 5'h0E, OP_RATE_Q      = 5'h0F
  } op_t;

  typedef enum logic [2:0] {
    GRP_L1 = 3'h0, GRP_L2 = 3'h1, GRP_M1 = 3'h2, GRP_M2 = 3'h3, GRP_H1 = 3'h4, GRP_H2 = 3'h5
  } rate_group_t;

  typedef struct packed {
    logic [4:0]  op;
    logic [3:0]  chan;
    logic [6:0]  seq;
    logic [6:0]  rate;
    logic [2:0]  group;
    logic [15:0] win_chan;
    logic [3:0]  keep_mask;
    logic        rom_sel;
    logic [1:0]  err_idx;
  } cmd_t;

  typedef struct packed {
    logic        is_action;
    logic [3:0]  chan;
    logic [6:0]  seq;
    logic [7:0]  code;
    logic [31:0] data;
  } tbl_wr_t;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  seq;
    logic [63:0] data;
  } reply_t;
endpackage

/* verification/host_model.sv */
// Host side model: issues decoded commands and schedule entries
module host_model
  import motion_cmd_pkg::*;
(
  // Clock
  input  wire logic   ref_clk,
  // Commands and replies
  output cmd_t        cmd,
  output logic        cmd_valid,
  input  wire reply_t reply,
  input  wire logic   reply_valid,
  // Schedule writes
  output tbl_wr_t     tbl_wr,
  output logic        tbl_wr_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd          = '0;
    cmd_valid    = 1'b0;
    tbl_wr       = '0;
    tbl_wr_valid = 1'b0;
  end
  // Released lines show the inverse, never the stale value
  task automatic ask(input cmd_t c, output reply_t r);
    @(negedge ref_clk);
    cmd       = c;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd       = ~c;
    r         = reply_valid ? reply : reply_t'('x);
  endtask
  task automatic go(input cmd_t c);
    reply_t unused;
    ask(c, unused);
  endtask
  // Entry number is 7 bits wide, so 0 to 127 only; lists end with an end entry
  task automatic put(input tbl_wr_t w);
    @(negedge ref_clk);
    tbl_wr       = w;
    tbl_wr_valid = 1'b1;
    @(negedge ref_clk);
    tbl_wr_valid = 1'b0;
    tbl_wr       = ~w;
  endtask
endmodule

/* verification/motion_cmd_chk.sv */
// Checker: port-level properties of the remote command core
module motion_cmd_chk
  import motion_cmd_pkg::*;
#(
  parameter int STAGGER_CYCLES = STAGGER_CYC
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // Commands and replies
  input wire logic        clk_en,
  input wire logic        cmd_valid,
  input wire cmd_t        cmd,
  input wire logic        remote_mode,
  input wire reply_t      reply,
  input wire logic        reply_valid,
  // Motion, errors, hand box
  input wire logic [15:0] chan_busy,
  input wire logic        busy_error,
  input wire logic        bad_abs_error,
  input wire logic [3:0]  change_detect,
  input wire logic [3:0]  ramping,
  input wire logic [3:0]  change_apply,
  input wire logic [15:0] window_chan,
  input wire logic [7:0]  error_flags,
  input wire logic        hb_button,
  input wire logic [2:0]  hb_lamps,
  input wire logic        remote_stop,
  input wire logic        restart_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Error sources win over clears, so clear checks need a quiet cycle
  wire logic        quiet  = !busy_error && !bad_abs_error;
  wire logic [7:0]  lowest = error_flags[0] ? 8'h00 : error_flags[1] ? 8'h01 :
                             error_flags[2] ? 8'h02 : 8'hFF;
  wire logic [15:0] win_exp;
  for (genvar p = 0; p < 4; p++) begin
    assign win_exp[4*p +: 4] = cmd.keep_mask[p] ? window_chan[4*p +: 4] : cmd.win_chan[4*p +: 4];
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take(logic [4:0] o); clk_en && cmd_valid && cmd.op == o; endsequence
  sequence s_staggered; change_apply == 4'h5 ##STAGGER_CYCLES change_apply == 4'hA; endsequence
  property p_flag_q; s_take(OP_ERR_FLAG_Q)
    |=> reply_valid && reply.code == $past(error_flags); endproperty
  a_flag_q: assert property (p_flag_q) else $error("flag reply wrong");
  property p_status_q; s_take(OP_ERR_STATUS_Q)
    |=> reply_valid && reply.code == $past(lowest); endproperty
  a_status_q: assert property (p_status_q) else $error("status reply wrong");
  property p_clr_all; s_take(OP_CLR_ALL) ##0 quiet |=> error_flags == 8'h00; endproperty
  a_clr_all: assert property (p_clr_all) else $error("clear all left bits");
  property p_clr_one;
    s_take(OP_CLR_ONE) ##0 quiet && cmd.err_idx != 2'h3
      |=> error_flags == ($past(error_flags) & ~(8'h01 << $past(cmd.err_idx)));
  endproperty
  a_clr_one: assert property (p_clr_one) else $error("indexed clear wrong");
  property p_assign; s_take(OP_ASSIGN) ##0 remote_mode && chan_busy == 16'h0000
    |=> window_chan == $past(win_exp); endproperty
  a_assign: assert property (p_assign) else $error("window map wrong");
  property p_refused; s_take(OP_ASSIGN) ##0 (!remote_mode || chan_busy == 16'hFFFF)
    |=> $stable(window_chan); endproperty
  a_refused: assert property (p_refused) else $error("refused map changed");
  property p_const; clk_en && change_detect[0] && !ramping[0] && change_detect != 4'hF
    |=> ##1 change_apply[0]; endproperty
  a_const: assert property (p_const) else $error("change late");
  property p_ramp_hold; clk_en && change_detect[1] && ramping[1] ##1 ramping[1]
    |=> !change_apply[1]; endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("change during ramp");
  property p_stagger; clk_en && change_detect == 4'hF && ramping == 4'h0
    |=> ##1 s_staggered; endproperty
  a_stagger: assert property (p_stagger) else $error("stagger wrong");
  property p_stop; clk_en && remote_mode && hb_lamps == 3'h7 && $rose(hb_button)
    |-> ##[1:2] remote_stop; endproperty
  a_stop: assert property (p_stop) else $error("no remote stop");
  property p_restart; s_take(OP_RESTART) ##0 remote_mode && quiet
    |=> restart_req && error_flags == 8'h00 && window_chan == WIN_RESET; endproperty
  a_restart: assert property (p_restart) else $error("restart incomplete");
endmodule

bind motion_cmd_core motion_cmd_chk #(.STAGGER_CYCLES(STAGGER_CYCLES)) chk (
  .ref_clk, .arst_n, .clk_en, .cmd_valid, .cmd, .remote_mode, .reply, .reply_valid, .chan_busy,
  .busy_error, .bad_abs_error, .change_detect, .ramping, .change_apply, .window_chan,
  .error_flags, .hb_button, .hb_lamps, .remote_stop, .restart_req
);

/* verification/motion_cmd_core_tb.sv */
// Testbench: remote command core driven through host command sequences
module motion_cmd_core_tb
  import motion_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STG = 8;
  localparam int HLD = 20;
  typedef struct packed {logic [4:0] op; logic [1:0] idx; logic [7:0] flg; logic [7:0] st;} step_t;
  logic        ref_clk, arst_n, clk_en, remote_mode, busy_error, bad_abs_error, hb_button;
  logic        cmd_valid, reply_valid, tbl_wr_valid, remote_stop, active_rom, restart_req;
  logic [15:0] chan_busy, window_chan;
  logic [3:0]  change_detect, ramping, change_apply;
  logic [63:0] chip_status;
  logic [7:0]  error_flags;
  logic [2:0]  hb_lamps;
  cmd_t        cmd, c;
  reply_t      reply, r;
  tbl_wr_t     tbl_wr;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n;
  logic [7:0]  pc [5] = '{PT_POSITION, PT_ELAPSED, PT_ACCEL_SPEED, PT_DECEL_SPEED, PT_END};
  logic [7:0]  ac [5] = '{ACT_NEW_SPEED, ACT_NEW_RATE, ACT_SLOW_STOP, ACT_FAST_STOP, ACT_SKIP};
  logic [6:0]  rt [4] = '{7'h00, 7'h29, 7'h73, 7'h3C};
  logic [2:0]  gp [4] = '{GRP_L1, GRP_H1, GRP_H2, GRP_M1};
  logic [63:0] ns [4] = '{64'h2FA_F080, 64'h2FA_F080, 64'h2_7100, 64'h19_2D50};
  step_t       steps [4] = '{'{OP_CLR_ONE, 2'h3, 8'h07, 8'h00}, '{OP_CLR_ONE, 2'h0, 8'h06, 8'h01},
                             '{OP_CLR_ONE, 2'h2, 8'h02, 8'h01}, '{OP_CLR_ALL, 2'h0, 8'h00, 8'hFF}};

  motion_cmd_core #(.STAGGER_CYCLES(STG), .HOLD_CYCLES(HLD)) dut (
    .ref_clk, .arst_n, .clk_en, .cmd_valid, .cmd, .remote_mode, .reply, .reply_valid,
    .tbl_wr_valid, .tbl_wr, .chan_busy, .busy_error, .bad_abs_error, .change_detect, .ramping,
    .chip_status, .change_apply, .window_chan, .error_flags, .hb_button, .hb_lamps,
    .remote_stop, .active_rom, .restart_req
  );
  host_model host (.ref_clk, .cmd, .cmd_valid, .reply, .reply_valid, .tbl_wr, .tbl_wr_valid);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic cmd_t cm(input op_t o, input logic [6:0] s = 7'h00);
    cmd_t x;
    x     = '0;
    x.op  = o;
    x.seq = s;
    return x;
  endfunction
  // Falling edges until the apply pattern shows, up to lim
  task automatic catch_apply(input logic [3:0] m, input int lim, output int k);
    k = 0;
    while (change_apply !== m && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, remote_mode, busy_error, bad_abs_error, hb_button} = 5'h00;
    clk_en = 1'b1;
    chan_busy = 16'h0000;
    change_detect = 4'h0;
    ramping = 4'h0;
    chip_status = 64'h0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    check("window_reset", window_chan, WIN_RESET);
    check("flags_reset", error_flags, ERR_RESET);
    busy_error = 1'b1;
    bad_abs_error = 1'b1;
    @(negedge ref_clk);
    busy_error = 1'b0;
    bad_abs_error = 1'b0;
    host.go(cm(op_t'(5'h10)));
    foreach (steps[i]) begin
      c = cm(op_t'(steps[i].op));
      c.err_idx = steps[i].idx;
      host.go(c);
      check("error_flags", error_flags, steps[i].flg);
      host.ask(cm(OP_ERR_FLAG_Q), r);
      check("flag_reply", r.code, steps[i].flg);
      host.ask(cm(OP_ERR_STATUS_Q), r);
      check("status_reply", r.code, steps[i].st);
    end
    for (int i = 0; i < 5; i++) begin
      logic [6:0] s;
      s = (i == 4) ? 7'h7F : 7'(i);
      host.put('{1'b0, 4'h5, s, pc[i], 32'hA000 + i});
      host.put('{1'b1, 4'h5, s, ac[i], 32'hB000 + i});
      c = cm(OP_POINT_RB, s);
      c.chan = 4'h5;
      host.ask(c, r);
      check("point_code", r.code, pc[i]);
      check("point_seq", r.seq, {1'b0, s});
      check("point_data", r.data[31:0], 32'hA000 + i);
      c.op = OP_ACTION_RB;
      host.ask(c, r);
      check("action_code", r.code, ac[i]);
      check("action_data", r.data[31:0], 32'hB000 + i);
    end
    chip_status = 64'h4444_3333_2222_1111;
    host.ask(cm(OP_CHIP_STAT_Q), r);
    check("chip_status", r.data, 64'h4444_3333_2222_1111);
    for (int i = 0; i < 4; i++) begin
      c = cm(OP_RATE_Q);
      c.rate = rt[i];
      c.group = gp[i];
      host.ask(c, r);
      check("ramp_period", r.data, ns[i]);
    end
    change_detect = 4'h1;
    @(negedge ref_clk);
    change_detect = 4'h0;
    catch_apply(4'h1, 3, n);
    check("apply_const", n, 1);
    ramping = 4'h2;
    change_detect = 4'h2;
    @(negedge ref_clk);
    change_detect = 4'h0;
    catch_apply(4'h2, 6, n);
    check("apply_held", n, 6);
    ramping = 4'h0;
    catch_apply(4'h2, 4, n);
    check("apply_ramp_end", n < 3, 1'b1);
    change_detect = 4'hF;
    @(negedge ref_clk);
    change_detect = 4'h0;
    catch_apply(4'h5, 3, n);
    check("apply_ac", n, 1);
    catch_apply(4'hA, 20, n);
    check("apply_bd", n, STG);
    remote_mode = 1'b1;
    c = cm(OP_ASSIGN);
    c.win_chan = 16'hFE98;
    c.keep_mask = 4'h4;
    host.go(c);
    host.ask(cm(OP_WIN_Q), r);
    check("window_reply", r.data[15:0], 16'hF298);
    chan_busy = 16'hFFFF;
    c.keep_mask = 4'h0;
    host.go(c);
    check("window_busy", window_chan, 16'hF298);
    chan_busy = 16'h0000;
    remote_mode = 1'b0;
    host.go(c);
    check("window_local", window_chan, 16'hF298);
    check("cmd_error", error_flags, 8'h01);
    remote_mode = 1'b1;
    hb_button = 1'b1;
    repeat (HLD - 2) @(negedge ref_clk);
    check("lamps_early", hb_lamps, 3'h0);
    repeat (7) @(negedge ref_clk);
    check("lamps_stop", hb_lamps, 3'h7);
    hb_button = 1'b0;
    @(negedge ref_clk);
    hb_button = 1'b1;
    @(negedge ref_clk);
    check("remote_stop", remote_stop, 1'b1);
    repeat (HLD + 5) @(negedge ref_clk);
    hb_button = 1'b0;
    @(negedge ref_clk);
    check("lamps_normal", hb_lamps, 3'h0);
    c = cm(OP_ROM_SEL);
    c.rom_sel = 1'b1;
    host.go(c);
    host.ask(cm(OP_ROM_Q), r);
    check("rom_before", r.code, 8'h00);
    host.go(cm(OP_RESTART));
    check("window_restart", window_chan, WIN_RESET);
    check("flags_restart", error_flags, 8'h00);
    host.ask(cm(OP_ROM_Q), r);
    check("rom_after", r.code, 8'h01);
    check("rom_port", active_rom, 1'b1);
    summarize();
  end
endmodule
